// ==== src/timer_cfg.svh ====
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// register byte offsets on the apb bus
`define OFF_CMD        8'h00
`define OFF_PERIOD_LO  8'h04
`define OFF_PERIOD_HI  8'h08
`define OFF_PIN_LEVEL  8'h0C
`define OFF_PIN_DIR    8'h10

// command codes in the low nibble of the command register
`define CMD_IRQ_ON     4'h1
`define CMD_IRQ_OFF    4'h2
`define CMD_ONESHOT    4'h3
`define CMD_RETRIG     4'h4
`define CMD_SRC_INT    4'h5
`define CMD_SRC_EXT    4'h6
`define CMD_ROUTE_ON   4'h7
`define CMD_ROUTE_OFF  4'h8
`define CMD_START      4'h9
`define CMD_STOP       4'hA
`define CMD_RESET      4'hB

// field positions
`define CMD_FIELD      3:0
`define LO_BYTE        7:0
`define HI_BYTE        15:8

// reset values
`define PERIOD_RST     16'h0000
`define DATA_ZERO      32'h00000000
`define PAD_24         24'h000000
`define PAD_7          7'h00

`endif

// ==== src/timer_pkg.sv ====
package timer_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b11
    } run_state_t;

    typedef enum logic {
        MODE_RETRIG  = 1'b0,
        MODE_ONESHOT = 1'b1
    } mode_t;

endpackage

// ==== src/edge_sync.sv ====
`timescale 1ns/100ps

module edge_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);

    logic meta;
    logic stage;
    logic prev;

    // meta feeds stage only; the edge detector looks at stage and prev
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta  <= 1'b0;
            stage <= 1'b0;
            prev  <= 1'b0;
        end else begin
            meta  <= async_in;
            stage <= meta;
            prev  <= stage;
        end
    end

    assign level = stage;
    assign rise  = stage && !prev;

endmodule

// ==== src/period_counter.sv ====
`timescale 1ns/100ps

module period_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             tick,
    output logic                  expire
);

    localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    logic [WIDTH-1:0] count;

    // a loaded value of zero or one expires on the first tick
    assign expire = tick && (count <= ONE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (tick && !expire) begin
            count <= count - ONE;
        end
    end

endmodule

// ==== src/interval_timer.sv ====
// Behaviour
// R1 - low nibble commands self-clear: 1001 start, 1010 stop, 1011 reset timer
// R2 - codes 1100 to 1111 do nothing; upper command bits are ignored
// R3 - command 0001 enables the timer interrupt, 0010 disables it
// R4 - command 0011 selects one-shot, 0100 selects re-triggerable operation
// R5 - command 0101 counts the internal clock, 0110 the external pin
// R6 - command 0111 routes timer output to pin zero, 1000 removes it
// R7 - software keeps the period between 0x0002 and 0xFFFF
// R8 - period splits into high half P and low half Q, Q gets the odd one
// R9 - one-shot output high while running, low and stays low after N clocks
// R10 - one-shot restart before timeout reloads the full N count
// R11 - after one-shot timeout start is ignored; only stop returns output high; the code also returns it high on the reset command
// R12 - once one-shot started, period writes and other commands are ignored
// R13 - re-triggerable output high P clocks, low Q clocks, high when stopped
// R14 - while re-triggerable runs, only stop and reset are accepted
// R15 - routed pin is forced output, driven high, pin registers lose control; the code drives it with timer_out instead
// R16 - interrupt at one-shot timeout, or at every re-triggerable rising edge
// R17 - command read gives 0x01 if enabled and pending; read or reset clears
// R18 - stop and later start leave a pending interrupt alone
// R19 - any reset stops timer, disables interrupt, re-trig, internal, unrouted
// R20 - period bytes read back as programmed, reset to zero, kept on reset cmd
// R21 - external count clock is synchronised, one count per rising edge
`timescale 1ns/100ps
`include "timer_cfg.svh"

module interval_timer #(
    parameter int PERIOD_W = 16
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_clock_pin,
    input  wire logic        multipurpose_pin_zero_in,
    output logic             multipurpose_pin_zero_out,
    output logic             multipurpose_pin_zero_oe_n,
    output logic             timer_out,
    output logic             timer_irq
);
    import timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    run_state_t          run_state;
    timer_pkg::mode_t    mode;
    logic                phase_high;
    logic                irq_en;
    logic                ext_src;
    logic                route;
    logic                pending;
    logic                read_snap;
    logic                pin_level;
    logic                pin_dir;
    logic [PERIOD_W-1:0] period;

    logic                ext_rise;
    logic                pin_sync_level;
    logic                expire;
    logic                tick;
    logic                setup;
    logic                access;
    logic                apb_wr;
    logic                apb_rd;
    logic                mapped;
    logic                cmd_wr;
    logic [3:0]          cmd;
    logic                blocked;
    logic                start_cmd;
    logic                stop_cmd;
    logic                reset_cmd;
    logic                cfg_ok;
    logic                start_ok;
    logic                timeout;
    logic                irq_set;
    logic                read_clear;
    logic                load;
    logic [PERIOD_W-1:0] load_value;
    logic [PERIOD_W-1:0] half_p;
    logic [PERIOD_W-1:0] half_q;
    logic [7:0]          next_byte;

    ////////////////////////////////////////////////////////////////////////
    // count source
    edge_sync u_ext_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (external_count_clock_pin),
        .level    (),
        .rise     (ext_rise)
    );

    edge_sync u_pin_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (multipurpose_pin_zero_in),
        .level    (pin_sync_level),
        .rise     ()
    );

    // internal source counts every pclk; the rate is fixed by pclk itself
    assign tick = ext_src ? ext_rise : 1'b1; // [R5] [R21]

    period_counter #(
        .WIDTH (PERIOD_W)
    ) u_counter (
        .clk        (pclk),
        .rst_n      (presetn),
        .load       (load),
        .load_value (load_value),
        .tick       (tick),
        .expire     (expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode and command decode
    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign apb_wr = access && pwrite;
    assign apb_rd = access && !pwrite;
    assign mapped = (paddr == `OFF_CMD) || (paddr == `OFF_PERIOD_LO) ||
                    (paddr == `OFF_PERIOD_HI) || (paddr == `OFF_PIN_LEVEL) ||
                    (paddr == `OFF_PIN_DIR);

    assign cmd_wr    = apb_wr && (paddr == `OFF_CMD);
    assign cmd       = pwdata[`CMD_FIELD]; // [R2]
    assign blocked   = (run_state != ST_IDLE); // [R12] [R14]
    assign start_cmd = cmd_wr && (cmd == `CMD_START); // [R1]
    assign stop_cmd  = cmd_wr && (cmd == `CMD_STOP); // [R1]
    assign reset_cmd = cmd_wr && (cmd == `CMD_RESET); // [R1]
    assign cfg_ok    = cmd_wr && !blocked; // [R12] [R14]

    // restart only reloads a one-shot still counting
    assign start_ok = start_cmd && ((run_state == ST_IDLE) ||
                      (mode == MODE_ONESHOT && run_state == ST_RUN)); // [R10] [R11] [R14]
    assign timeout  = expire && (run_state == ST_RUN) && !start_ok &&
                      !stop_cmd && !reset_cmd;

    // odd leftover goes to the low phase
    assign half_p = period >> 1; // [R8]
    assign half_q = period - half_p; // [R8]

    always_comb begin
        load       = 1'b0;
        load_value = period;
        if (start_ok) begin
            load       = 1'b1;
            load_value = (mode == MODE_ONESHOT) ? period : half_p; // [R10]
        end else if (timeout && mode == MODE_RETRIG) begin
            load       = 1'b1;
            load_value = phase_high ? half_q : half_p; // [R13]
        end
    end

    assign irq_set    = timeout && ((mode == MODE_ONESHOT) || !phase_high); // [R16]
    assign read_clear = apb_rd && (paddr == `OFF_CMD) && read_snap; // [R17]

    ////////////////////////////////////////////////////////////////////////
    // run state and timer output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state  <= ST_IDLE; // [R19]
            timer_out  <= 1'b1;
            phase_high <= 1'b1;
        end else if (reset_cmd || stop_cmd) begin
            run_state  <= ST_IDLE; // [R11] [R13] [R19]
            timer_out  <= 1'b1;
            phase_high <= 1'b1;
        end else if (start_ok) begin
            run_state  <= ST_RUN; // [R9]
            timer_out  <= 1'b1;
            phase_high <= 1'b1;
        end else if (timeout) begin
            case (mode)
                MODE_ONESHOT: begin
                    run_state <= ST_DONE; // [R9]
                    timer_out <= 1'b0;
                end
                MODE_RETRIG: begin
                    phase_high <= !phase_high; // [R13]
                    timer_out  <= !phase_high;
                end
                default: begin
                    run_state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration set by commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en  <= 1'b0; // [R19]
            mode    <= MODE_RETRIG;
            ext_src <= 1'b0;
            route   <= 1'b0;
        end else if (reset_cmd) begin
            irq_en  <= 1'b0; // [R19]
            mode    <= MODE_RETRIG;
            ext_src <= 1'b0;
            route   <= 1'b0;
        end else if (cfg_ok) begin
            // reserved codes fall through with no action
            case (cmd)
                `CMD_IRQ_ON:    irq_en  <= 1'b1; // [R3]
                `CMD_IRQ_OFF:   irq_en  <= 1'b0; // [R3]
                `CMD_ONESHOT:   mode    <= MODE_ONESHOT; // [R4]
                `CMD_RETRIG:    mode    <= MODE_RETRIG; // [R4]
                `CMD_SRC_INT:   ext_src <= 1'b0; // [R5]
                `CMD_SRC_EXT:   ext_src <= 1'b1; // [R5]
                `CMD_ROUTE_ON:  route   <= 1'b1; // [R6]
                `CMD_ROUTE_OFF: route   <= 1'b0; // [R6]
                default:        route   <= route; // [R2]
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period bytes, untouched by the reset command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period <= `PERIOD_RST; // [R20]
        end else if (apb_wr && !blocked) begin // [R12] [R14]
            if (paddr == `OFF_PERIOD_LO) begin
                period[`LO_BYTE] <= pwdata[`LO_BYTE];
            end
            if (paddr == `OFF_PERIOD_HI) begin
                period[`HI_BYTE] <= pwdata[`LO_BYTE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending interrupt: a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
        end else if (irq_set) begin
            pending <= 1'b1; // [R16]
        end else if (read_clear || reset_cmd) begin
            pending <= 1'b0; // [R17] [R18]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= irq_en && pending; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: read data is captured in setup, zero wait states
    always_comb begin
        next_byte = 8'h00;
        case (paddr)
            `OFF_CMD:       next_byte = {`PAD_7, irq_en && pending}; // [R17]
            `OFF_PERIOD_LO: next_byte = period[`LO_BYTE]; // [R20]
            `OFF_PERIOD_HI: next_byte = period[`HI_BYTE]; // [R20]
            `OFF_PIN_LEVEL: next_byte = {`PAD_7, pin_sync_level};
            `OFF_PIN_DIR:   next_byte = {`PAD_7, pin_dir};
            default:        next_byte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= `DATA_ZERO;
            read_snap <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata    <= pwrite ? `DATA_ZERO : {`PAD_24, next_byte};
                // only what was reported (or hidden by the mask) is cleared
                read_snap <= !pwrite && (paddr == `OFF_CMD) && pending;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin zero: pin registers and timer routing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level <= 1'b0;
            pin_dir   <= 1'b0;
        end else if (apb_wr) begin
            if (paddr == `OFF_PIN_LEVEL) begin
                pin_level <= pwdata[0];
            end
            if (paddr == `OFF_PIN_DIR) begin
                pin_dir <= pwdata[0];
            end
        end
    end

    // pin comes up as an input; output enable is active low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            multipurpose_pin_zero_out  <= 1'b0;
            multipurpose_pin_zero_oe_n <= 1'b1;
        end else begin
            multipurpose_pin_zero_out  <= route ? timer_out : pin_level; // [R15]
            multipurpose_pin_zero_oe_n <= !(route || pin_dir); // [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_reserved_no_action: assert property ( // [R2]
        (cmd_wr && cmd >= 4'hC) |=>
            ($stable(run_state) && $stable(irq_en) && $stable(mode) &&
             $stable(ext_src) && $stable(route))
    ) else $error("reserved command changed timer state");
    a_irq_enable_cmd: assert property ( // [R3]
        (cfg_ok && cmd == `CMD_IRQ_ON && !reset_cmd) |=> irq_en
    ) else $error("interrupt enable command not taken");
    a_oneshot_stays_low: assert property ( // [R9]
        (run_state == ST_DONE && !stop_cmd && !reset_cmd) |->
            !timer_out ##1 (!timer_out && run_state == ST_DONE)
    ) else $error("one-shot output high after timeout");
    a_stopped_out_high: assert property ( // [R13]
        (stop_cmd && !reset_cmd) |=> (timer_out && run_state == ST_IDLE)
    ) else $error("output not high after stop");
    a_period_blocked: assert property ( // [R12]
        (apb_wr && blocked) |=> $stable(period)
    ) else $error("period written while running");
    a_reset_defaults: assert property ( // [R19]
        reset_cmd |=> (!irq_en && mode == MODE_RETRIG && !ext_src &&
                       !route && run_state == ST_IDLE && !pending)
    ) else $error("reset command left non-default settings");
    a_irq_on_timeout: assert property ( // [R16]
        irq_set |=> pending ##1 (timer_irq == $past(irq_en))
    ) else $error("timeout did not raise pending interrupt");
    a_stop_keeps_pending: assert property ( // [R18]
        (pending && (stop_cmd || start_cmd) && !read_clear) |=> pending
    ) else $error("stop or start cleared pending interrupt");
    a_status_read: assert property ( // [R17]
        (setup && !pwrite && paddr == `OFF_CMD) |=>
            (prdata == {`PAD_24, `PAD_7, $past(irq_en) && $past(pending)})
    ) else $error("command register read value wrong");
    a_route_drives_pin: assert property ( // [R15]
        route |=> (!multipurpose_pin_zero_oe_n &&
                   multipurpose_pin_zero_out == $past(timer_out))
    ) else $error("routed pin not driven by timer");

    c_oneshot_timeout: cover property (mode == MODE_ONESHOT &&
        run_state == ST_RUN ##1 run_state == ST_DONE);
    c_retrig_rise: cover property (mode == MODE_RETRIG && irq_set);
    c_status_clear: cover property (read_clear ##1 !pending);
    c_oneshot_restart: cover property (start_ok && run_state == ST_RUN);

endmodule

// ==== verif/interval_timer_tb_top.sv ====
`timescale 1ns/100ps
`include "timer_cfg.svh"

module interval_timer_tb_top;
    import timer_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clk;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe_n;
    logic        timer_out;
    logic        timer_irq;
    int          fail_count;
    int          cmp_count;
    logic [31:0] rd;
    logic        err;
    logic        prev;
    int          n;
    int          k;

    interval_timer #(.PERIOD_W(16)) u_dut (
        .pclk                       (pclk),
        .presetn                    (presetn),
        .psel                       (psel),
        .penable                    (penable),
        .pwrite                     (pwrite),
        .paddr                      (paddr),
        .pwdata                     (pwdata),
        .prdata                     (prdata),
        .pready                     (pready),
        .pslverr                    (pslverr),
        .external_count_clock_pin   (ext_clk),
        .multipurpose_pin_zero_in   (pin_in),
        .multipurpose_pin_zero_out  (pin_out),
        .multipurpose_pin_zero_oe_n (pin_oe_n),
        .timer_out                  (timer_out),
        .timer_irq                  (timer_irq)
    );

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic timed_out(input string what);
        fail_count++;
        $display("MISMATCH %s expected done seen timeout", what);
        results();
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int w;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 16);
        if (pready !== 1'b1) timed_out("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic [3:0] c);
        apb(1'b1, `OFF_CMD, {28'h0000000, c});
    endtask

    task automatic rdchk(input string name, input logic [7:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, `DATA_ZERO);
        check(name, rd, exp);
    endtask

    task automatic set_n(input int v);
        apb(1'b1, `OFF_PERIOD_LO, {24'h000000, 8'(v)});
        apb(1'b1, `OFF_PERIOD_HI, {24'h000000, 8'(v >> 8)});
    endtask

    // cycles that timer_out keeps the given level, from just after now
    task automatic measure(input logic lvl, input int lim, input bit must,
                           output int c);
        c = 0;
        #1;
        while (timer_out === lvl && c < lim) begin
            @(posedge pclk);
            #1;
            c++;
        end
        if (must && c == lim) timed_out("timer_out phase");
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask

    task automatic ext_pulse();
        @(posedge pclk);
        ext_clk <= 1'b1;
        repeat (3) @(posedge pclk);
        ext_clk <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // model of the phase split: high half rounds down, low half gets rest
    function automatic int exp_p(input int v);
        return v / 2;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        ext_clk = 1'b0;
        pin_in = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        void'($urandom(59942));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // defaults after hardware reset
        rdchk("period_lo", `OFF_PERIOD_LO, 32'h00000000);
        rdchk("period_hi", `OFF_PERIOD_HI, 32'h00000000);
        rdchk("cmd_rd", `OFF_CMD, 32'h00000000);
        check("out_idle", timer_out, 1'b1);
        check("oe_idle", pin_oe_n, 1'b1);
        apb(1'b0, 8'h14, `DATA_ZERO);
        check("unmapped_err", err, 1'b1);
        check("unmapped_rd", rd, 32'h00000000);
        pin_in <= 1'($urandom % 2);
        settle(4);
        rdchk("pin_level", `OFF_PIN_LEVEL, {31'h00000000, pin_in});
        $display("test reset done");
        // one-shot runs with random period
        for (int i = 0; i < 3; i++) begin
            n = 16 + ($urandom % 40);
            cmd(`CMD_ONESHOT);
            cmd(`CMD_IRQ_ON);
            set_n(n);
            cmd(`CMD_START);
            apb(1'b1, `OFF_PERIOD_LO, 32'h00000001);
            cmd(`CMD_RETRIG);
            cmd(`CMD_START);
            measure(1'b1, 200, 1'b1, k);
            check("oneshot_len", k, n);
            settle(1);
            check("irq_timeout", timer_irq, 1'b1);
            cmd(`CMD_START);
            measure(1'b0, 6, 1'b0, k);
            check("stays_low", k, 6);
            rdchk("keep_lo", `OFF_PERIOD_LO, 32'(n % 256));
            rdchk("keep_hi", `OFF_PERIOD_HI, 32'(n / 256));
            cmd(`CMD_STOP);
            settle(1);
            check("stop_high", timer_out, 1'b1);
            apb(1'b1, `OFF_CMD, 32'h000000F9);
            rdchk("pend_kept", `OFF_CMD, 32'h00000001);
            rdchk("pend_clr", `OFF_CMD, 32'h00000000);
            settle(2);
            check("irq_clr", timer_irq, 1'b0);
            cmd(`CMD_STOP);
        end
        $display("test oneshot done");
        // reserved codes and disabled interrupt
        cmd(`CMD_IRQ_OFF);
        set_n(4);
        for (int c = 0; c < 5; c++) begin
            cmd((c == 0) ? 4'h0 : 4'(4'hB + c));
        end
        settle(8);
        check("no_action", timer_out, 1'b1);
        cmd(`CMD_START);
        measure(1'b1, 50, 1'b1, k);
        check("oneshot_n4", k, 4);
        settle(2);
        check("irq_off", timer_irq, 1'b0);
        rdchk("rd_off", `OFF_CMD, 32'h00000000);
        cmd(`CMD_STOP);
        $display("test reserved done");
        // re-triggerable after reset command, odd then even period
        set_n(7);
        cmd(`CMD_RESET);
        rdchk("reset_keeps", `OFF_PERIOD_LO, 32'h00000007);
        apb(1'b1, `OFF_PIN_DIR, 32'h00000001);
        apb(1'b1, `OFF_PIN_LEVEL, 32'h00000000);
        settle(2);
        check("pin_drv", {pin_oe_n, pin_out}, 2'b00);
        cmd(`CMD_ROUTE_ON);
        settle(2);
        check("route_on", {pin_oe_n, pin_out}, 2'b01);
        apb(1'b1, `OFF_PIN_DIR, 32'h00000000);
        settle(2);
        check("route_lock", {pin_oe_n, pin_out}, 2'b01);
        cmd(`CMD_IRQ_ON);
        for (int j = 0; j < 2; j++) begin
            n = (j == 0) ? 7 : 6;
            set_n(n);
            cmd(`CMD_START);
            measure(1'b1, 100, 1'b1, k);
            measure(1'b0, 100, 1'b1, k);
            check("low_q", k, n - exp_p(n));
            measure(1'b1, 100, 1'b1, k);
            check("high_p", k, exp_p(n));
            cmd(`CMD_START);
            apb(1'b1, `OFF_PERIOD_LO, 32'h00000009);
            cmd(`CMD_IRQ_OFF);
            measure(1'b0, 100, 1'b1, k);
            measure(1'b1, 100, 1'b1, k);
            measure(1'b0, 100, 1'b1, k);
            check("low_q2", k, n - exp_p(n));
            prev = timer_out;
            for (int t = 0; t < 2 * n; t++) begin
                settle(1);
                check("pin_follow", pin_out, prev);
                prev = timer_out;
            end
            rdchk("retrig_irq", `OFF_CMD, 32'h00000001);
            rdchk("keep_lo2", `OFF_PERIOD_LO, 32'(n));
            cmd(`CMD_STOP);
            settle(1);
            check("retrig_stop", timer_out, 1'b1);
        end
        cmd(`CMD_ROUTE_OFF);
        apb(1'b1, `OFF_PIN_DIR, 32'h00000001);
        settle(2);
        check("route_off", {pin_oe_n, pin_out}, 2'b00);
        $display("test retrig done");
        // external count source, then reset command after one-shot timeout
        cmd(`CMD_ONESHOT);
        cmd(`CMD_SRC_EXT);
        set_n(4);
        cmd(`CMD_START);
        repeat (3) ext_pulse();
        settle(8);
        check("ext_wait", timer_out, 1'b1);
        ext_pulse();
        settle(8);
        check("ext_done", timer_out, 1'b0);
        cmd(`CMD_STOP);
        cmd(`CMD_SRC_INT);
        cmd(`CMD_ROUTE_ON);
        cmd(`CMD_START);
        measure(1'b1, 50, 1'b1, k);
        check("int_src", k, 4);
        cmd(`CMD_RESET);
        settle(2);
        check("rst_cmd_out", timer_out, 1'b1);
        check("rst_unroute", {pin_oe_n, pin_out}, 2'b00);
        cmd(`CMD_IRQ_ON);
        rdchk("rst_clr", `OFF_CMD, 32'h00000000);
        cmd(`CMD_START);
        measure(1'b1, 100, 1'b1, k);
        check("rst_p", k, 2);
        measure(1'b0, 100, 1'b1, k);
        check("rst_retrig", k, 2);
        $display("test external done");
        results();
    end
endmodule
